/* rtl/erpsc_pkg.sv */
// Constants for the exit/reverse path stepper control block.
// Assumes a single 25 MHz clock; all timing counts derive from it.
package erpsc_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ = 25000000;
	localparam int SWITCHBACK_DELAY_US = 100000;
	localparam int SWITCHBACK_DELAY_CYC = SWITCHBACK_DELAY_US * (CLK_HZ / 1000000);
	localparam int PERIOD_W = 20;
	localparam logic [PERIOD_W-1:0] START_PERIOD_RST = 20'h186a0;
	localparam logic [PERIOD_W-1:0] RUN_PERIOD_RST = 20'h061a8;
	localparam logic [PERIOD_W-1:0] HIGH_PERIOD_RST = 20'h030d4;
	localparam logic [PERIOD_W-1:0] RAMP_STEP_RST = 20'h00100;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ERPSC_IDLE = 3'b000,
		ERPSC_INFEED = 3'b001,
		ERPSC_WAIT = 3'b010,
		ERPSC_BACK = 3'b011,
		ERPSC_DISCHARGE = 3'b100,
		ERPSC_DUPLEX = 3'b101,
		ERPSC_STRAIGHT = 3'b110
	} erpsc_state_t;
endpackage : erpsc_pkg

/* rtl/erpsc_stepper.sv */
// One ramped stepper channel: step pulse, four phases, speed-mode level.
// Assumes the start period is stable while running; inputs are synchronous.
module erpsc_stepper #(
	parameter int PW = 20
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Control
	input wire logic run,
	input wire logic dir_rev,
	input wire logic [PW-1:0] start_period,
	input wire logic [PW-1:0] target_period,
	input wire logic [PW-1:0] ramp_step,
	// Outputs
	output logic step_clock,
	output logic [3:0] phase,
	output logic at_speed
);
	logic [PW-1:0] cur_reg, cur_next, cnt_reg;
	logic [1:0] idx_reg;
	logic step_reg;
	logic stop_done;
	wire run_or_ramp = run || !stop_done;
	wire tick = run_or_ramp && (cnt_reg == '0);
	wire [PW:0] up = {1'b0, cur_reg} + {1'b0, ramp_step};
	wire [PW:0] dn = {1'b0, cur_reg} - {1'b0, ramp_step};
	// Stopping is done once we are back at the start period
	assign stop_done = (cur_reg >= start_period);
	// Target depends on run: ramp down to start rate when stopping
	wire [PW-1:0] goal = run ? target_period : start_period;
	// Period slews by ramp_step per step toward goal, no overshoot
	always_comb begin
		cur_next = cur_reg;
		if (cur_reg > goal) begin
			cur_next = (dn[PW] || dn[PW-1:0] < goal) ? goal : dn[PW-1:0];
		end else if (cur_reg < goal) begin
			cur_next = (up[PW] || up[PW-1:0] > goal) ? goal : up[PW-1:0];
		end
	end
	// Period counter, step pulse and phase index
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cur_reg <= '1;
			cnt_reg <= '0;
			idx_reg <= 2'h0;
			step_reg <= 1'b0;
		end else if (!run_or_ramp) begin
			cur_reg <= start_period;
			cnt_reg <= '0;
			step_reg <= 1'b0;
		end else if (tick) begin
			cur_reg <= cur_next;
			// Count down from period minus one so a step lasts exactly cur_next cycles
			cnt_reg <= cur_next - 1'b1;
			step_reg <= 1'b1;
			idx_reg <= dir_rev ? idx_reg - 2'h1 : idx_reg + 2'h1;
		end else begin
			cnt_reg <= cnt_reg - 1'b1;
			// Step clock is a half-ish duty pulse: high for first half
			if (cnt_reg == {1'b0, cur_reg[PW-1:1]}) step_reg <= 1'b0;
		end
	end
	assign step_clock = step_reg;
	always_comb begin
		unique case (idx_reg)
			2'h0: phase = 4'b0011;
			2'h1: phase = 4'b0110;
			2'h2: phase = 4'b1100;
			2'h3: phase = 4'b1001;
		endcase
	end
	// constant speed once period meets target
	assign at_speed = run && (cur_reg == target_period);
endmodule // erpsc_stepper

/* rtl/erpsc_top.sv */
// Exit/reverse path sequencer with two stepper channels.
// Assumes sensors and commands are synchronous to clock, external drivers
// convert phase and step levels to motor current.
// Function
// - Gate rests at reverse path; solenoid energised only when no reverse runs.
// - Trailing edge past fuser sensor raises reverse path speed to high.
// - After speed change wait configurable interval then reverse drive to switch back.
// - Discharged sheet keeps high speed to exit roller and out.
// - Duplex sheet goes to horizontal transport; speed returns to normal then.
// - Duplex second pass: gate switches so sheet goes straight out.
// - Four exit phase outputs; speed set by phase pulse timing.
// - Exit speed mode low while ramping, high at constant speed.
// - Reverse driver steps only while active-low enable is low.
// - Reverse direction select low forward, high reverse.
// - Reverse speed mode low while ramping, high at constant speed.
// - Reverse speed changed by step clock period.
module erpsc_top
	import erpsc_pkg::*;
#(
	parameter int SWITCHBACK_CYC = erpsc_pkg::SWITCHBACK_DELAY_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Job commands
	input wire logic sheet_start,
	input wire logic duplex_mode,
	input wire logic second_pass,
	input wire logic handoff_done,
	input wire logic exit_done,
	// Sensors
	input wire logic fuser_exit_sheet_sensor,
	input wire logic reverse_path_sensor_a,
	input wire logic reverse_path_sensor_b,
	// Speed settings
	input wire logic [erpsc_pkg::PERIOD_W-1:0] start_period,
	input wire logic [erpsc_pkg::PERIOD_W-1:0] run_period,
	input wire logic [erpsc_pkg::PERIOD_W-1:0] high_period,
	input wire logic [erpsc_pkg::PERIOD_W-1:0] ramp_step,
	// Gate
	output logic gate_solenoid,
	// Exit stepper
	output logic exit_phase_a,
	output logic exit_phase_b,
	output logic exit_phase_c,
	output logic exit_phase_d,
	output logic exit_speed_mode,
	// Reverse stepper
	output logic reverse_step_clock,
	output logic reverse_drive_enable_n,
	output logic reverse_speed_mode,
	output logic reverse_direction_select,
	// Status
	output logic busy,
	output logic sheet_in_reverse_path
);
	import erpsc_pkg::*;
	// ==========================================================
	// Sequencer
	erpsc_state_t state_reg, state_next;
	logic [31:0] wait_reg;
	logic sensor_reg;
	logic rev_run, rev_back, exit_run;
	logic [PERIOD_W-1:0] rev_target;
	logic [3:0] exit_phase;
	logic rev_at_speed, exit_at_speed;
	logic gate_reg, dir_reg, en_n_reg;
	// Trailing edge of sheet leaving the fuser sensor
	wire trail_edge = sensor_reg && !fuser_exit_sheet_sensor;
	wire wait_done = (wait_reg == 32'h0000_0001);
	// Next-state decode
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ERPSC_IDLE: begin
				if (sheet_start) state_next = second_pass ? ERPSC_STRAIGHT : ERPSC_INFEED;
			end
			ERPSC_INFEED: if (trail_edge) state_next = ERPSC_WAIT;
			ERPSC_WAIT: if (wait_done) state_next = ERPSC_BACK;
			ERPSC_BACK: state_next = duplex_mode ? ERPSC_DUPLEX : ERPSC_DISCHARGE;
			ERPSC_DISCHARGE: if (exit_done) state_next = ERPSC_IDLE;
			ERPSC_DUPLEX: if (handoff_done) state_next = ERPSC_IDLE;
			ERPSC_STRAIGHT: if (exit_done) state_next = ERPSC_IDLE;
			default: state_next = ERPSC_IDLE;
		endcase
	end
	// State, interval counter and sensor history
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ERPSC_IDLE;
			wait_reg <= 32'h0;
			sensor_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sensor_reg <= fuser_exit_sheet_sensor;
			if (state_reg == ERPSC_INFEED && trail_edge) begin
				wait_reg <= 32'(SWITCHBACK_CYC);
			end else if (wait_reg != 32'h0) begin
				wait_reg <= wait_reg - 32'h1;
			end
		end
	end
	// ==========================================================
	// Drive decisions
	// gate toward exit only when no reverse operation is in progress
	// Preset at the accepted start only, so an idle gate never stays energised
	wire gate_next = (state_reg == ERPSC_STRAIGHT)
		|| (state_reg == ERPSC_IDLE && second_pass && sheet_start);
	// high speed while discharging, normal for duplex hand-off
	assign rev_run = (state_reg != ERPSC_IDLE) && (state_reg != ERPSC_STRAIGHT);
	assign rev_back = (state_reg == ERPSC_BACK) || (state_reg == ERPSC_DISCHARGE)
		|| (state_reg == ERPSC_DUPLEX);
	assign rev_target = (state_reg == ERPSC_INFEED || state_reg == ERPSC_DUPLEX)
		? run_period : high_period;
	// Exit roller turns whenever a sheet is heading out
	assign exit_run = (state_reg == ERPSC_DISCHARGE) || (state_reg == ERPSC_STRAIGHT)
		|| (state_reg == ERPSC_BACK && !duplex_mode);
	// Registered level outputs
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gate_reg <= 1'b0;
			dir_reg <= 1'b0;
			en_n_reg <= 1'b1;
		end else begin
			gate_reg <= gate_next;
			dir_reg <= rev_back;
			en_n_reg <= !rev_run;
		end
	end
	// ==========================================================
	// Stepper channels
	erpsc_stepper #(.PW(PERIOD_W)) u_exit (
		.clock(clock),
		.rst_b(rst_b),
		.run(exit_run),
		.dir_rev(1'b0),
		.start_period(start_period),
		.target_period(high_period),
		.ramp_step(ramp_step),
		.step_clock(),
		.phase(exit_phase),
		.at_speed(exit_at_speed)
	);
	erpsc_stepper #(.PW(PERIOD_W)) u_rev (
		.clock(clock),
		.rst_b(rst_b),
		.run(rev_run),
		.dir_rev(rev_back),
		.start_period(start_period),
		.target_period(rev_target),
		.ramp_step(ramp_step),
		.step_clock(reverse_step_clock),
		.phase(),
		.at_speed(rev_at_speed)
	);
	assign exit_phase_a = exit_phase[0];
	assign exit_phase_b = exit_phase[1];
	assign exit_phase_c = exit_phase[2];
	assign exit_phase_d = exit_phase[3];
	assign exit_speed_mode = exit_at_speed;
	// reverse speed mode, only meaningful while enabled
	assign reverse_speed_mode = rev_at_speed && !en_n_reg;
	assign gate_solenoid = gate_reg;
	assign reverse_direction_select = dir_reg;
	assign reverse_drive_enable_n = en_n_reg;
	assign busy = (state_reg != ERPSC_IDLE);
	// Path sensors only report occupancy; jam checks live elsewhere
	assign sheet_in_reverse_path = reverse_path_sensor_a || reverse_path_sensor_b;
endmodule // erpsc_top

/* tb/erpsc_top_checker.sv */
// Concurrent checks on the exit/reverse sequencer ports.
// Assumes it is bound to erpsc_top and sees only its ports.
module erpsc_top_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Watched ports
	input wire logic sheet_start,
	input wire logic second_pass,
	input wire logic gate_solenoid,
	input wire logic exit_phase_a,
	input wire logic exit_phase_b,
	input wire logic exit_phase_c,
	input wire logic exit_phase_d,
	input wire logic reverse_step_clock,
	input wire logic reverse_drive_enable_n,
	input wire logic reverse_speed_mode,
	input wire logic busy
);
	// ==========================================================
	// Helpers
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic [3:0] ph_reg;
	wire logic [3:0] ph = {exit_phase_d, exit_phase_c, exit_phase_b, exit_phase_a};
	wire logic [3:0] ph_up = {ph_reg[2:0], ph_reg[3]};
	wire logic [3:0] ph_dn = {ph_reg[0], ph_reg[3:1]};
	// Last phase, so a jump of two steps is seen
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			ph_reg <= 4'h3;
		else
			ph_reg <= ph;
	end
	sequence s_idle_start;
		sheet_start && !busy && !second_pass;
	endsequence
	sequence s_drive_on;
		##[1:3] !reverse_drive_enable_n;
	endsequence
	chk_gate_busy: assert property (gate_solenoid |-> busy || $past(busy))
		else $error("gate energised with no job");
	chk_speed_enabled: assert property (reverse_speed_mode |-> !reverse_drive_enable_n)
		else $error("reverse speed mode while disabled");
	chk_phase_legal: assert property (ph inside {4'h3, 4'h6, 4'hc, 4'h9})
		else $error("exit phase pattern illegal");
	chk_phase_order: assert property (ph != ph_reg |-> ph == ph_up || ph == ph_dn)
		else $error("exit phase skipped a step");
	chk_step_pulse: assert property ($rose(reverse_step_clock) |=> reverse_step_clock)
		else $error("step clock pulse too narrow");
	chk_busy_cause: assert property ($rose(busy) |-> $past(sheet_start))
		else $error("busy without start");
	chk_start_drive: assert property (s_idle_start |-> s_drive_on)
		else $error("reverse drive not enabled after start");
	chk_enable_job: assert property (!reverse_drive_enable_n |-> busy || $past(busy))
		else $error("reverse drive enabled while idle");
endmodule // erpsc_top_checker

bind erpsc_top erpsc_top_checker u_chk (.clock, .rst_b, .sheet_start, .second_pass,
	.gate_solenoid, .exit_phase_a, .exit_phase_b, .exit_phase_c, .exit_phase_d,
	.reverse_step_clock, .reverse_drive_enable_n, .reverse_speed_mode, .busy);

/* tb/erpsc_driver_model.sv */
// Reverse motor driver stage: windings step on each rising step clock edge while enabled.
// Assumes step, enable and direction come from erpsc_top.
module erpsc_driver_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Driver controls
	input wire logic step,
	input wire logic en_n,
	input wire logic dir,
	// Windings and tally
	output logic [3:0] winding,
	output int steps
);
	timeunit 1ns;
	timeprecision 1ps;
	logic step_reg;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			winding <= 4'h3;
			steps <= 0;
			step_reg <= 1'b0;
		end else begin
			step_reg <= step;
			if (step && !step_reg && !en_n) begin
				steps <= steps + 1;
				winding <= dir ? {winding[0], winding[3:1]} : {winding[2:0], winding[3]};
			end
		end
	end
endmodule // erpsc_driver_model

/* tb/erpsc_top_bench.sv */
// Self-checking bench for erpsc_top: simplex, duplex and straight sheets.
// Assumes a short switchback count and small step periods.
module erpsc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Stimulus and observation
	localparam int SWB = 200;
	logic clock = 0, rst_b = 0, st = 0, dup = 0, sec = 0, hd = 0, ed = 0, fs = 1, sa = 0, sb = 0;
	logic gate, pa, pb, pc, pd, em, rsc, ren, rsm, rdir, busy, sirp;
	logic [3:0] wind;
	int failures = 0, n_compared = 0, p, i, steps;
	always #20 clock = ~clock;
	erpsc_top #(.SWITCHBACK_CYC(SWB)) DUT (.clock, .rst_b, .sheet_start(st), .duplex_mode(dup),
		.second_pass(sec), .handoff_done(hd), .exit_done(ed), .fuser_exit_sheet_sensor(fs),
		.reverse_path_sensor_a(sa), .reverse_path_sensor_b(sb), .start_period(20'h28),
		.run_period(20'h14), .high_period(20'h0a), .ramp_step(20'h05), .gate_solenoid(gate),
		.exit_phase_a(pa), .exit_phase_b(pb), .exit_phase_c(pc), .exit_phase_d(pd),
		.exit_speed_mode(em), .reverse_step_clock(rsc), .reverse_drive_enable_n(ren),
		.reverse_speed_mode(rsm), .reverse_direction_select(rdir), .busy(busy),
		.sheet_in_reverse_path(sirp));
	erpsc_driver_model u_drv (.clock, .rst_b, .step(rsc), .en_n(ren), .dir(rdir),
		.winding(wind), .steps(steps));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Settle at speed, then time one step in clock cycles
	task meas;
		for (i = 0; i < 999 && rsm !== 1'b1; i++) cyc(1);
		for (p = 0; p < 999 && rsc !== 1'b0; p++) cyc(1);
		for (p = 0; p < 999 && rsc !== 1'b1; p++) cyc(1);
		p = 0;
		do begin
			cyc(1);
			p++;
		end while (rsc === 1'b1 && p < 999);
		do begin
			cyc(1);
			p++;
		end while (rsc !== 1'b1 && p < 999);
	endtask
	task sheet(input logic d, input logic s);
		fs = 1;
		dup = d;
		sec = s;
		st = 1;
		cyc(1);
		st = 0;
		cyc(3);
		chk("gate", gate, s);
		if (!s) begin
			chk("drive", {ren, rdir}, 2'b00);
			meas;
			chk("run_period", p, 20);
			fs = 0;
			cyc(4);
			chk("ramping", rsm, 0);
			for (i = 4; i < 999 && rdir !== 1'b1; i++) cyc(1);
			chk("switchback", i >= SWB && i <= SWB + 6, 1);
			sa = !d;
			sb = d;
			cyc(1);
			chk("in_path", {sirp, gate}, 2'b10);
			meas;
			chk("back_period", p, d ? 20 : 10);
			for (i = 0; i < 999 && !d && em !== 1'b1; i++) cyc(1);
			chk("exit_mode", em, !d);
			chk("steps", steps > 0, 1);
			// Start while busy must be ignored
			st = 1;
			cyc(1);
			st = 0;
		end
		hd = d;
		ed = !d;
		cyc(1);
		hd = 0;
		ed = 0;
		cyc(4);
		chk("idle", {busy, ren, gate}, 3'b010);
	endtask
	initial begin
		cyc(9);
		chk("reset", {gate, ren, rdir, busy, em, rsm, rsc}, 7'b0100000);
		cyc(1);
		rst_b = 1;
		sheet(0, 0);
		sheet(1, 0);
		sheet(0, 1);
		report_and_stop;
	end
	// Watchdog well past the three sheets
	initial begin
		#1000000;
		failures++;
		report_and_stop;
	end
endmodule // erpsc_top_bench
